// *** bcc_regs.sv ***
// Purpose: Charger configuration registers and the charge timer sequencer they steer.
// Assumes: Serial slave presents a one-cycle write strobe with address and byte.
// Notes: Timer tick is a parameter so simulation can shorten hours to cycles.
`timescale 1ns/1ps
`default_nettype none

module bcc_regs #(
  parameter int TICK_CYC = bcc_pkg::TICK_CYCLES,
  parameter int TICKS_PER_MIN = bcc_pkg::TICKS_PER_MIN
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port from serial slave
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Analog front end status
  input wire logic battery_present,
  input wire logic above_precharge_threshold,
  input wire logic below_cutoff_current,
  input wire logic thermal_regulation,
  input wire logic input_droop_regulation,
  // Charger controls
  output logic charging,
  output logic fast_charge,
  output logic charge_timer_expired,
  output bcc_pkg::bcc_analog_t analog_cfg
);

  // ********************
  // Registers
  // ********************
  bcc_pkg::bcc_setup_one_t one_ff;
  bcc_pkg::bcc_setup_two_t two_ff;
  bcc_pkg::bcc_setup_three_t three_ff;
  logic restart_seen_ff;
  logic restart_pulse;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      one_ff <= bcc_pkg::RST_SETUP_ONE;
      two_ff <= bcc_pkg::RST_SETUP_TWO;
      three_ff <= bcc_pkg::RST_SETUP_THREE;
    end else if (reg_wr) begin
      case (reg_addr)
        bcc_pkg::OFS_SETUP_ONE: one_ff <= reg_wdata;
        bcc_pkg::OFS_SETUP_TWO: two_ff <= reg_wdata;
        bcc_pkg::OFS_SETUP_THREE: three_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Restart fires on the falling write of the reset bit, after it was held set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_seen_ff <= 1'b0;
    end else begin
      restart_seen_ff <= one_ff.charger_restart;
    end
  end
  assign restart_pulse = restart_seen_ff && !one_ff.charger_restart;

  // ********************
  // Read mux
  // ********************
  bcc_pkg::bcc_state_t state_ff;
  logic pre_expired_ff;
  logic fast_expired_ff;

  always_comb begin
    reg_rdata = 8'h00;
    case (reg_addr)
      bcc_pkg::OFS_SETUP_ONE: reg_rdata = one_ff;
      bcc_pkg::OFS_SETUP_TWO: reg_rdata = two_ff;
      bcc_pkg::OFS_SETUP_THREE: reg_rdata = three_ff;
      bcc_pkg::OFS_CHG_STATUS: begin
        reg_rdata[bcc_pkg::POS_TIMER_EXPIRED] = charge_timer_expired;
        reg_rdata[bcc_pkg::POS_PRE_EXPIRED] = pre_expired_ff;
        reg_rdata[bcc_pkg::POS_ACTIVE] = charging;
      end
      default: reg_rdata = 8'h00;
    endcase
  end

  // ********************
  // Timer tick
  // ********************
  // Half rate under regulation: every other tick is swallowed
  logic [31:0] tick_cnt_ff;
  logic tick;
  logic half_ff;
  logic slow;
  logic run;

  assign slow = two_ff.timer_half_rate_on_regulation
      && (thermal_regulation || input_droop_regulation);
  assign run = one_ff.safety_timers_on && !one_ff.timers_freeze;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= 32'h0000_0000;
    end else if (tick_cnt_ff >= 32'(TICK_CYC - 1)) begin
      tick_cnt_ff <= 32'h0000_0000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_ff <= 1'b0;
    end else if (tick_cnt_ff == 32'h0000_0000) begin
      half_ff <= !half_ff;
    end
  end

  assign tick = (tick_cnt_ff == 32'h0000_0000) && run
      && (!slow || half_ff);

  // ********************
  // Limits in minutes
  // ********************
  function automatic logic [31:0] hours_min(input logic [1:0] sel);
    logic [31:0] h;
    h = 32'h0000_0006;
    case (sel)
      2'b00: h = 32'h0000_0004;
      2'b01: h = 32'h0000_0005;
      2'b10: h = 32'h0000_0006;
      default: h = 32'h0000_0008;
    endcase
    return h * 32'(bcc_pkg::MIN_PER_HOUR);
  endfunction : hours_min

  logic [31:0] pre_limit;
  logic [31:0] fast_limit;
  // Limits in ticks; a short minute lets a bench reach the timeouts
  assign pre_limit = 32'(TICKS_PER_MIN) * (three_ff.precharge_duration_sel
      ? 32'(bcc_pkg::PRE_LONG_MIN) : 32'(bcc_pkg::PRE_SHORT_MIN));
  assign fast_limit = 32'(TICKS_PER_MIN) * hours_min(one_ff.safety_hours_sel);

  // ********************
  // Charge sequencer
  // ********************
  logic [31:0] elapsed_ff;
  bcc_pkg::bcc_state_t nxt_state;
  logic enabled;

  assign enabled = one_ff.charger_on && !one_ff.charger_restart;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      bcc_pkg::ST_IDLE:
        if (enabled && battery_present) begin
          nxt_state = above_precharge_threshold ? bcc_pkg::ST_FAST : bcc_pkg::ST_PRE;
        end
      bcc_pkg::ST_PRE:
        if (above_precharge_threshold) begin
          nxt_state = bcc_pkg::ST_FAST;
        end else if (one_ff.safety_timers_on && elapsed_ff >= pre_limit) begin
          nxt_state = bcc_pkg::ST_DONE;
        end
      bcc_pkg::ST_FAST:
        if (one_ff.safety_timers_on && elapsed_ff >= fast_limit) begin
          nxt_state = bcc_pkg::ST_DONE;
        end else if (!one_ff.cutoff_disable && below_cutoff_current) begin
          nxt_state = bcc_pkg::ST_DONE;
        end
      bcc_pkg::ST_DONE: nxt_state = bcc_pkg::ST_DONE;
      default: nxt_state = bcc_pkg::ST_IDLE;
    endcase
    if (!enabled || restart_pulse) begin
      nxt_state = bcc_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= bcc_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Elapsed ticks restart on every phase change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_ff <= 32'h0000_0000;
    end else if (nxt_state != state_ff) begin
      elapsed_ff <= 32'h0000_0000;
    end else if (tick) begin
      elapsed_ff <= elapsed_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_expired_ff <= 1'b0;
      fast_expired_ff <= 1'b0;
    end else if (nxt_state == bcc_pkg::ST_IDLE) begin
      pre_expired_ff <= 1'b0;
      fast_expired_ff <= 1'b0;
    end else if (nxt_state == bcc_pkg::ST_DONE && state_ff != bcc_pkg::ST_DONE) begin
      pre_expired_ff <= (state_ff == bcc_pkg::ST_PRE) && !above_precharge_threshold;
      fast_expired_ff <= (state_ff == bcc_pkg::ST_FAST)
          && one_ff.safety_timers_on && elapsed_ff >= fast_limit;
    end
  end

  assign charge_timer_expired = pre_expired_ff || fast_expired_ff;
  assign charging = (state_ff == bcc_pkg::ST_PRE) || (state_ff == bcc_pkg::ST_FAST);
  assign fast_charge = (state_ff == bcc_pkg::ST_FAST);

  // ********************
  // Analog settings
  // ********************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_cfg <= '0;
    end else begin
      case (three_ff.charge_current_sel)
        2'b00: analog_cfg.charge_current_ma <= 10'd300;
        2'b01: analog_cfg.charge_current_ma <= 10'd400;
        2'b10: analog_cfg.charge_current_ma <= 10'd500;
        default: analog_cfg.charge_current_ma <= 10'd700;
      endcase
      case (three_ff.power_path_droop_threshold)
        2'b00: analog_cfg.droop_mv_div10 <= 9'd350;
        2'b01: analog_cfg.droop_mv_div10 <= 9'd375;
        2'b10: analog_cfg.droop_mv_div10 <= 9'd400;
        default: analog_cfg.droop_mv_div10 <= 9'd425;
      endcase
      case (three_ff.cutoff_current_factor)
        2'b00: analog_cfg.cutoff_permille <= 8'd25;
        2'b01: analog_cfg.cutoff_permille <= 8'd75;
        2'b10: analog_cfg.cutoff_permille <= 8'd150;
        default: analog_cfg.cutoff_permille <= 8'd180;
      endcase
      analog_cfg.precharge_mv_div10 <= two_ff.precharge_threshold_sel
          ? 9'd250 : 9'd290;
      analog_cfg.temp_max_c <= three_ff.charge_temp_window_sel ? 7'd60 : 7'd45;
      analog_cfg.thermistor_curve_sel <= one_ff.thermistor_curve_sel;
      analog_cfg.charge_voltage_sel <= two_ff.charge_voltage_sel;
    end
  end

endmodule : bcc_regs

`default_nettype wire

// *** bcc_pkg.sv ***
// Purpose: Constants and carrier types for the charger configuration register bank.
// Assumes: Byte-wide register port from the serial slave, one clock, async active-low reset.
// Notes: Offsets are byte addresses on the serial register map.
//
// What this block does
// - A two-bit field, reset 10, picks the fast-charge safety timer: 4, 5, 6 or 8 hours.
// - A timer-enable bit, reset 1, turns both the precharge and fast-charge timers on or off.
// - A thermistor-curve bit, reset 1, picks the 100k curve at 0 and the 10k curve at 1.
// - The charger-reset bit resets to 0; host writes 1 then 0, and charging restarts.
// - Termination-disable at 0 ends charging on timers and current; at 1 current cut-off is skipped.
// - The suspend bit, reset 0, freezes the safety and precharge timers while set.
// - The charger-enable bit, reset 1, turns the charger off at 0 and on at 1.
// - The dynamic-timer bit, reset 1, halves the timer rate while a regulation loop is active.
// - A precharge-threshold bit, reset 0, sets the hand-over at 2.9 V or 2.5 V.
// - A two-bit charge-current field, reset 10, selects 300, 400, 500 or 700 mA.
// - A two-bit droop threshold field, reset 11, selects 3.5, 3.75, 4 or 4.25 V.
// - A precharge-time bit, reset 0, sets the precharge timer to 30 or 60 minutes.
// - The cut-off current is charge current times 2.5, 7.5, 15 or 18 percent, field reset 01.
// - A temperature-window bit, reset 0, allows charging at 0 to 45 or 0 to 60 degrees.
// - When an enabled charge timer expires, charging stops and a read-only flag shows it.

package bcc_pkg;

  // ********************
  // Register map
  // ********************
  localparam logic [7:0] OFS_SETUP_ONE = 8'h04;
  localparam logic [7:0] OFS_SETUP_TWO = 8'h05;
  localparam logic [7:0] OFS_SETUP_THREE = 8'h06;
  localparam logic [7:0] OFS_CHG_STATUS = 8'h03;

  localparam logic [7:0] RST_SETUP_ONE = 8'hB1;
  localparam logic [7:0] RST_SETUP_TWO = 8'h80;
  localparam logic [7:0] RST_SETUP_THREE = 8'hB2;

  // Status byte positions
  localparam int POS_TIMER_EXPIRED = 2;
  localparam int POS_PRE_EXPIRED = 1;
  localparam int POS_ACTIVE = 3;

  // ********************
  // Timing
  // ********************
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int MIN_PER_HOUR = 60;
  localparam int TICKS_PER_MIN = 60_000;
  localparam int PRE_SHORT_MIN = 30;
  localparam int PRE_LONG_MIN = 60;

  // ********************
  // Carrier types
  // ********************
  typedef struct packed {
    logic [1:0] safety_hours_sel;
    logic safety_timers_on;
    logic thermistor_curve_sel;
    logic charger_restart;
    logic cutoff_disable;
    logic timers_freeze;
    logic charger_on;
  } bcc_setup_one_t;

  typedef struct packed {
    logic timer_half_rate_on_regulation;
    logic precharge_threshold_sel;
    logic [1:0] charge_voltage_sel;
    logic [3:0] spare;
  } bcc_setup_two_t;

  typedef struct packed {
    logic [1:0] charge_current_sel;
    logic [1:0] power_path_droop_threshold;
    logic precharge_duration_sel;
    logic [1:0] cutoff_current_factor;
    logic charge_temp_window_sel;
  } bcc_setup_three_t;

  // Analog settings decoded from the bank
  typedef struct packed {
    logic [9:0] charge_current_ma;
    logic [8:0] droop_mv_div10;
    logic [7:0] cutoff_permille;
    logic [8:0] precharge_mv_div10;
    logic [6:0] temp_max_c;
    logic thermistor_curve_sel;
    logic [1:0] charge_voltage_sel;
  } bcc_analog_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE = 2'b01,
    ST_FAST = 2'b10,
    ST_DONE = 2'b11
  } bcc_state_t;

endpackage : bcc_pkg

// *** bcc_regs_properties.sv ***
// Purpose: Port-level checks for the charger configuration bank.
// Assumes: One clock, async active-low reset, byte write strobe.
// Notes: Decoded settings are given two edges after the write strobe.
`timescale 1ns/1ps
`default_nettype none

module bcc_regs_properties #(
  parameter int TICK_CYC = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Charger side
  input wire logic charging,
  input wire logic charge_timer_expired,
  input wire bcc_pkg::bcc_analog_t analog_cfg
);
  // ********************
  // Properties
  // ********************
  localparam int CUR[4] = '{300, 400, 500, 700};
  localparam int DRP[4] = '{350, 375, 400, 425};
  localparam int CUT[4] = '{25, 75, 150, 180};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_readback;
    reg_wr && reg_addr inside {8'h04, 8'h05, 8'h06} ##1 reg_addr == $past(reg_addr)
      |-> reg_rdata == $past(reg_wdata);
  endproperty
  property p_cur;
    reg_wr && reg_addr == 8'h06 |-> ##2 analog_cfg.charge_current_ma == CUR[$past(reg_wdata[7:6], 2)];
  endproperty
  property p_droop;
    reg_wr && reg_addr == 8'h06 |-> ##2 analog_cfg.droop_mv_div10 == DRP[$past(reg_wdata[5:4], 2)];
  endproperty
  property p_cutoff;
    reg_wr && reg_addr == 8'h06 |-> ##2 analog_cfg.cutoff_permille == CUT[$past(reg_wdata[2:1], 2)];
  endproperty
  property p_temp;
    reg_wr && reg_addr == 8'h06 |-> ##2 analog_cfg.temp_max_c == ($past(reg_wdata[0], 2) ? 7'h3C : 7'h2D);
  endproperty
  property p_prethr;
    reg_wr && reg_addr == 8'h05
      |-> ##2 analog_cfg.precharge_mv_div10 == ($past(reg_wdata[6], 2) ? 9'h0FA : 9'h122);
  endproperty
  property p_ntc;
    reg_wr && reg_addr == 8'h04 |-> ##2 analog_cfg.thermistor_curve_sel == $past(reg_wdata[4], 2);
  endproperty
  property p_vsel;
    reg_wr && reg_addr == 8'h05
      |-> ##2 analog_cfg.charge_voltage_sel == $past(reg_wdata[5:4], 2);
  endproperty
  property p_off;
    (reg_addr == 8'h04 && !reg_rdata[0]) [*3] |-> !charging;
  endproperty
  property p_hold;
    (reg_addr == 8'h04 && reg_rdata[3]) [*3] |-> !charging;
  endproperty
  property p_status;
    reg_addr == 8'h03 |-> reg_rdata[3] == charging && reg_rdata[2] == charge_timer_expired;
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");
  a_cur: assert property (p_cur) else $error("charge current decode wrong");
  a_droop: assert property (p_droop) else $error("droop threshold decode wrong");
  a_cutoff: assert property (p_cutoff) else $error("cutoff factor decode wrong");
  a_temp: assert property (p_temp) else $error("temperature window decode wrong");
  a_prethr: assert property (p_prethr) else $error("precharge threshold wrong");
  a_ntc: assert property (p_ntc) else $error("thermistor curve wrong");
  a_vsel: assert property (p_vsel) else $error("charge voltage select wrong");
  a_off: assert property (p_off) else $error("charging while disabled");
  a_hold: assert property (p_hold) else $error("charging during restart");
  a_status: assert property (p_status) else $error("status byte wrong");
  c_restart: cover property (reg_wr && reg_addr == 8'h04 && reg_wdata[3]);
  c_charge: cover property ($rose(charging));
  c_max: cover property (analog_cfg.charge_current_ma == 10'h2BC);
  c_timeout: cover property ($rose(charge_timer_expired));
endmodule : bcc_regs_properties

bind bcc_regs bcc_regs_properties #(.TICK_CYC(TICK_CYC)) u_props (
  .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .charging(charging), .charge_timer_expired(charge_timer_expired),
  .analog_cfg(analog_cfg)
);

`default_nettype wire

// *** bcc_host_model.sv ***
// Purpose: Host side of the register port, one byte per access.
// Assumes: Signals change 1 ns after a rising edge.
// Notes: Stands in for the serial slave that fronts the bank.
`timescale 1ns/1ps
`default_nettype none

module bcc_host_model (
  // Clock and read data
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  // Request
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    // Scramble data so a late sample cannot pass
    #1 reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    #2 d = reg_rdata;
  endtask : rd
endmodule : bcc_host_model

`default_nettype wire

// *** bcc_regs_tb_top.sv ***
// Purpose: Self-checking bench for the charger configuration bank.
// Assumes: TICK_CYC of 1 and two ticks a minute, so timeouts end in hundreds of cycles.
// Notes: Regulation inputs toggle at random; thermal regulation is held high while loop_hold is set.
`timescale 1ns/1ps
`default_nettype none

module bcc_regs_tb_top;
  logic clk = 1'b0;
  logic rst_n, reg_wr, battery_present, above_th, below_cut, therm, droop, loop_hold;
  logic charging, fast_charge, charge_timer_expired;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, a;
  logic [31:0] seed;
  logic [31:0] bg = 32'hC7AC;
  bcc_pkg::bcc_analog_t analog_cfg;
  int n_mismatch, check_count;

  bcc_regs #(.TICK_CYC(1), .TICKS_PER_MIN(2)) DUT (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .battery_present(battery_present),
    .above_precharge_threshold(above_th), .below_cutoff_current(below_cut),
    .thermal_regulation(therm), .input_droop_regulation(droop), .charging(charging),
    .fast_charge(fast_charge), .charge_timer_expired(charge_timer_expired), .analog_cfg(analog_cfg));
  bcc_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));

  // ********************
  // Helpers
  // ********************
  always #5 clk = ~clk;
  always @(posedge clk) begin
    bg <= lfsr(bg);
    therm <= #1 bg[0] | loop_hold;
    droop <= #1 bg[1];
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(ad, v);
    chk(v, exp);
  endtask : rd_chk
  task automatic wait_chg(input logic lvl);
    for (int i = 0; i < 40 && charging !== lvl; i++) begin
      @(posedge clk);
      #1;
    end
    chk({7'h00, charging}, {7'h00, lvl});
  endtask : wait_chg
  task automatic hold_then_end(input int n);
    repeat (n) @(posedge clk);
    #1 chk({7'h00, charging}, 8'h01);
    wait_chg(1'b0);
  endtask : hold_then_end
  // Leaving the done phase needs a pass through disable
  task automatic restart_with(input logic [7:0] cfg);
    host.wr(8'h04, cfg & 8'hFE);
    host.wr(8'h04, cfg);
  endtask : restart_with
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // ********************
  // Sequence
  // ********************
  initial begin
    rst_n = 1'b0;
    {battery_present, above_th, below_cut, loop_hold} = 4'h0;
    seed = 32'hC7AC;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    rd_chk(8'h04, 8'hB1);
    rd_chk(8'h05, 8'h80);
    rd_chk(8'h06, 8'hB2);
    for (int j = 0; j < 12; j++) begin
      a = 8'h04 + j[7:0] / 4;
      host.wr(a, 8'h55 * j[1:0]);
      rd_chk(a, 8'h55 * j[1:0]);
    end
    for (int i = 0; i < 30; i++) begin
      seed = lfsr(seed);
      a = 8'h04 + {6'h00, seed[9:8]};
      host.wr(a, seed[7:0]);
      rd_chk(a, (a == 8'h07) ? 8'h00 : seed[7:0]);
    end
    host.wr(8'h05, 8'h80);
    host.wr(8'h06, 8'hB2);
    host.wr(8'h04, 8'hB1);
    battery_present = 1'b1;
    wait_chg(1'b1);
    host.wr(8'h04, 8'hB0);
    wait_chg(1'b0);
    host.wr(8'h04, 8'hB1);
    wait_chg(1'b1);
    host.wr(8'h04, 8'hB9);
    wait_chg(1'b0);
    host.wr(8'h04, 8'hB1);
    wait_chg(1'b1);
    host.wr(8'h04, 8'hB5);
    above_th = 1'b1;
    below_cut = 1'b1;
    repeat (30) @(posedge clk);
    #1 chk({7'h00, charging}, 8'h01);
    host.wr(8'h04, 8'hB1);
    wait_chg(1'b0);
    // Timed phases at nominal rate with regulation inputs ignored, then at half rate under held thermal regulation
    host.wr(8'h05, 8'h00);
    above_th = 1'b0;
    below_cut = 1'b0;
    restart_with(8'hB1);
    hold_then_end(40);
    rd_chk(8'h03, 8'h06);
    host.wr(8'h06, 8'hBA);
    restart_with(8'hB1);
    hold_then_end(90);
    host.wr(8'h06, 8'hB2);
    host.wr(8'h05, 8'h80);
    loop_hold = 1'b1;
    restart_with(8'hB1);
    hold_then_end(90);
    loop_hold = 1'b0;
    host.wr(8'h05, 8'h00);
    restart_with(8'h91);
    repeat (150) @(posedge clk);
    #1 chk({7'h00, charging}, 8'h01);
    host.wr(8'h04, 8'hB3);
    repeat (150) @(posedge clk);
    #1 chk({7'h00, charging}, 8'h01);
    host.wr(8'h04, 8'hB1);
    hold_then_end(40);
    above_th = 1'b1;
    restart_with(8'h31);
    @(posedge clk);
    #1 chk({7'h00, fast_charge}, 8'h01);
    hold_then_end(450);
    rd_chk(8'h03, 8'h04);
    restart_with(8'hF1);
    hold_then_end(930);
    // Reset in mid-run clears status and restores the bank
    battery_present = 1'b0;
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h04, 8'hB1);
    rd_chk(8'h05, 8'h80);
    end_of_test();
  end

  // Generous bound: the sequence needs a few thousand cycles
  initial begin
    #500000;
    n_mismatch++;
    end_of_test();
  end
endmodule : bcc_regs_tb_top

`default_nettype wire
